// ==== rtl/tcx_trap_map.svh ====
`ifndef TCX_TRAP_MAP_SVH
`define TCX_TRAP_MAP_SVH

`define TCX_NUM_CLASSES 8
`define TCX_NUM_SYNC 24
`define TCX_ENTRY_SHIFT 5

`define TCX_CLS_MMU 3'h0
`define TCX_CLS_PROT 3'h1
`define TCX_CLS_INSTR 3'h2
`define TCX_CLS_CTX 3'h3
`define TCX_CLS_BUS 3'h4
`define TCX_CLS_ASSERT 3'h5
`define TCX_CLS_SYSTEM_CALL_INSTRUCTION 3'h6
`define TCX_CLS_NMI 3'h7

`define TCX_ID_VAF 8'h00
`define TCX_ID_VAP 8'h01
`define TCX_ID_PRIVILEGED_INSTRUCTION_TRAP 8'h01
`define TCX_ID_MPR 8'h02
`define TCX_ID_MPW 8'h03
`define TCX_ID_MPX 8'h04
`define TCX_ID_MPP 8'h05
`define TCX_ID_MPN 8'h06
`define TCX_ID_GLOBAL_REG_WRITE_TRAP 8'h07
`define TCX_ID_ILLEGAL_OPCODE_TRAP 8'h01
`define TCX_ID_ALN 8'h04
`define TCX_ID_MEM 8'h05
`define TCX_ID_FCD 8'h01
`define TCX_ID_CDO 8'h02
`define TCX_ID_CDU 8'h03
`define TCX_ID_FCU 8'h04
`define TCX_ID_CSU 8'h05
`define TCX_ID_CONTEXT_TYPE_TRAP 8'h06
`define TCX_ID_NESTING_ERROR_TRAP 8'h07
`define TCX_ID_PSE 8'h01
`define TCX_ID_DSE 8'h02
`define TCX_ID_DAE 8'h03
`define TCX_ID_OVF 8'h01
`define TCX_ID_STICKY_OVERFLOW_TRAP 8'h02
`define TCX_ID_NMI 8'h00

// Bit positions of i_sync_req; lower index wins
`define TCX_SRC_ILLEGAL_OPCODE_TRAP 9
`define TCX_SRC_FCU 15
`define TCX_SRC_SYS 23

`endif

// ==== rtl/tcx_pkg.sv ====
package tcx_pkg;
  typedef logic [2:0] tcx_class_t;
  typedef logic [7:0] tcx_id_t;
  typedef enum logic {TCX_IDLE, TCX_ENTER} tcx_state_e;
endpackage

// ==== rtl/tcx_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcx_sync2 (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;
  logic q_r;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule
`default_nettype wire

// ==== rtl/tcx_trap_classifier.sv ====
// Function
// - Trap entry never writes the current CPU priority field
// - No control can mask or disable any trap class
// - Abort current instruction and redirect fetch to the selected handler
// - Saved return address defaults to the trapping instruction, re-executed later
// - Every trap reported as three-bit class plus eight-bit identification
// - Class alone indexes trap vector table, separate from interrupt table
// - Identification written to data register fifteen before handler runs, except on free list underflow
// - Exactly eight trap classes, numbered 0 to 7
// - Class 0: fill id 0, protection id 1, save current PC
// - Class 1: protection traps ids 1 to 7, save current PC
// - Class 2: illegal opcode 1, misalignment 4, invalid address 5
// - Class 3: context traps ids 1 to 7; all but 4 save current PC
// - Class 4: fetch 1, load 2 synchronous; store 3 asynchronous
// - Class 5: overflow 1, sticky overflow 2, save current PC
// - Class 6 system call saves the following instruction PC
// - Class 7 from external input, watchdog or clock loss
// - System call always traps; illegal opcode aborts and traps
// - System call identification is the instruction immediate, 0 to 255
// - Free list underflow jumps straight to its own handler
// - Synchronous traps taken at once, before execution advances
`include "tcx_trap_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tcx_trap_classifier #(
  parameter int unsigned ENTRY_SHIFT = `TCX_ENTRY_SHIFT
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [`TCX_NUM_SYNC-1:0] i_sync_req,
  input wire logic [31:0] i_this_pc,
  input wire logic [31:0] i_next_pc,
  input wire logic [7:0] i_system_call_instruction_imm,
  input wire logic i_store_err,
  input wire logic i_wdt_nmi,
  input wire logic i_clk_loss,
  input wire logic i_nmi_pin,
  input wire logic [31:0] i_vec_base,
  input wire logic [31:0] i_fcu_handler,
  output logic o_abort,
  output logic o_fcu_jump,
  output logic [31:0] o_fetch_addr,
  output logic [2:0] o_class,
  output logic [7:0] o_id,
  output logic [31:0] o_save_pc,
  output logic o_save_we,
  output logic o_d15_we,
  output logic [31:0] o_d15_data,
  output logic o_prio_we
);
  // Refuse shifts that would push the class bits past the address
  if (ENTRY_SHIFT < 2 || ENTRY_SHIFT > 24) begin : g_bad_shift
    $error("ENTRY_SHIFT out of range");
  end

  tcx_pkg::tcx_state_e state_r;
  tcx_pkg::tcx_class_t sel_cls;
  tcx_pkg::tcx_id_t sel_id;
  tcx_pkg::tcx_class_t cls_r;
  tcx_pkg::tcx_id_t id_r;
  logic [31:0] sel_pc;
  logic [31:0] save_pc_r;
  logic [31:0] fetch_r;
  logic sel_fcu;
  logic fcu_r;
  logic sync_any;
  logic take_sync;
  logic take_async;
  logic take;
  logic nmi_s;
  logic nmi_prev_r;
  logic nmi_evt;
  logic nmi_pend_r;
  logic store_pend_r;
  logic take_nmi;
  logic take_store;

  // Class and identification of each synchronous source
  function automatic logic [10:0] src_code(input int unsigned idx);
    logic [10:0] c;
    c = {`TCX_CLS_MMU, `TCX_ID_VAF};
    unique case (idx)
      0: c = {`TCX_CLS_MMU, `TCX_ID_VAF};
      1: c = {`TCX_CLS_MMU, `TCX_ID_VAP};
      2: c = {`TCX_CLS_PROT, `TCX_ID_PRIVILEGED_INSTRUCTION_TRAP};
      3: c = {`TCX_CLS_PROT, `TCX_ID_MPR};
      4: c = {`TCX_CLS_PROT, `TCX_ID_MPW};
      5: c = {`TCX_CLS_PROT, `TCX_ID_MPX};
      6: c = {`TCX_CLS_PROT, `TCX_ID_MPP};
      7: c = {`TCX_CLS_PROT, `TCX_ID_MPN};
      8: c = {`TCX_CLS_PROT, `TCX_ID_GLOBAL_REG_WRITE_TRAP};
      9: c = {`TCX_CLS_INSTR, `TCX_ID_ILLEGAL_OPCODE_TRAP};
      10: c = {`TCX_CLS_INSTR, `TCX_ID_ALN};
      11: c = {`TCX_CLS_INSTR, `TCX_ID_MEM};
      12: c = {`TCX_CLS_CTX, `TCX_ID_FCD};
      13: c = {`TCX_CLS_CTX, `TCX_ID_CDO};
      14: c = {`TCX_CLS_CTX, `TCX_ID_CDU};
      15: c = {`TCX_CLS_CTX, `TCX_ID_FCU};
      16: c = {`TCX_CLS_CTX, `TCX_ID_CSU};
      17: c = {`TCX_CLS_CTX, `TCX_ID_CONTEXT_TYPE_TRAP};
      18: c = {`TCX_CLS_CTX, `TCX_ID_NESTING_ERROR_TRAP};
      19: c = {`TCX_CLS_BUS, `TCX_ID_PSE};
      20: c = {`TCX_CLS_BUS, `TCX_ID_DSE};
      21: c = {`TCX_CLS_ASSERT, `TCX_ID_OVF};
      22: c = {`TCX_CLS_ASSERT, `TCX_ID_STICKY_OVERFLOW_TRAP};
      default: c = {`TCX_CLS_SYSTEM_CALL_INSTRUCTION, 8'h00};
    endcase
    return c;
  endfunction

  tcx_sync2 u_nmi_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_d(i_nmi_pin),
    .o_q(nmi_s)
  );

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      nmi_prev_r <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_s;
    end
  end

  assign nmi_evt = (nmi_s & ~nmi_prev_r) | i_wdt_nmi | i_clk_loss;

  // Nothing here can mask a request
  assign sync_any = |i_sync_req;
  assign take_sync = (state_r == tcx_pkg::TCX_IDLE) && sync_any;
  assign take_async = (state_r == tcx_pkg::TCX_IDLE) && !sync_any
                      && (nmi_pend_r || store_pend_r);
  assign take_nmi = take_async && nmi_pend_r;
  assign take_store = take_async && !nmi_pend_r;
  assign take = take_sync || take_async;

  // Asynchronous events wait here; a new event beats the clear
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_pend_r <= nmi_evt | (nmi_pend_r & ~take_nmi);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      store_pend_r <= 1'b0;
    end else begin
      store_pend_r <= i_store_err | (store_pend_r & ~take_store);
    end
  end

  always_comb begin
    logic [10:0] code;
    code = 11'h000;
    sel_cls = `TCX_CLS_NMI;
    sel_id = `TCX_ID_NMI;
    sel_pc = i_next_pc;
    sel_fcu = 1'b0;
    if (sync_any) begin
      for (int i = `TCX_NUM_SYNC - 1; i >= 0; i--) begin
        if (i_sync_req[i]) begin
          code = src_code(i);
          sel_fcu = (i == `TCX_SRC_FCU);
        end
      end
      sel_cls = code[10:8];
      sel_id = code[7:0];
      sel_pc = i_this_pc;
      if (code[10:8] == `TCX_CLS_SYSTEM_CALL_INSTRUCTION) begin
        sel_id = i_system_call_instruction_imm;
        sel_pc = i_next_pc;
      end
    end else if (!nmi_pend_r) begin
      sel_cls = `TCX_CLS_BUS;
      sel_id = `TCX_ID_DAE;
      sel_pc = i_this_pc;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= tcx_pkg::TCX_IDLE;
    end else begin
      unique case (state_r)
        tcx_pkg::TCX_IDLE: begin
          if (take) begin
            state_r <= tcx_pkg::TCX_ENTER;
          end
        end
        tcx_pkg::TCX_ENTER: begin
          state_r <= tcx_pkg::TCX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cls_r <= 3'h0;
      id_r <= 8'h00;
      save_pc_r <= 32'h0000_0000;
      fcu_r <= 1'b0;
      fetch_r <= 32'h0000_0000;
    end else if (take) begin
      cls_r <= sel_cls;
      id_r <= sel_id;
      save_pc_r <= sel_pc;
      fcu_r <= sel_fcu;
      if (sel_fcu) begin
        fetch_r <= i_fcu_handler;
      end else begin
        fetch_r <= i_vec_base + (32'(sel_cls) << ENTRY_SHIFT);
      end
    end
  end

  assign o_abort = (state_r == tcx_pkg::TCX_ENTER);
  assign o_fcu_jump = o_abort && fcu_r;
  assign o_fetch_addr = fetch_r;
  assign o_class = cls_r;
  assign o_id = id_r;
  assign o_save_pc = save_pc_r;
  assign o_save_we = o_abort && !fcu_r;
  assign o_d15_we = o_abort && !fcu_r;
  assign o_d15_data = {24'h00_0000, id_r};
  assign o_prio_we = 1'b0;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_prio_untouched: assert property (o_abort |-> !o_prio_we)
    else $error("priority written during trap entry");

  a_sync_taken_now: assert property (
    (state_r == tcx_pkg::TCX_IDLE && sync_any) |=> o_abort)
    else $error("synchronous trap not taken next cycle");

  a_vector_addr: assert property (
    (take && !sel_fcu) |=>
      o_fetch_addr == $past(i_vec_base) + (32'(o_class) << ENTRY_SHIFT))
    else $error("vector address wrong");

  a_system_call_instruction_entry: assert property (
    (state_r == tcx_pkg::TCX_IDLE && i_sync_req == (24'h1 << `TCX_SRC_SYS)) |=>
      (o_class == 3'h6 && o_id == $past(i_system_call_instruction_imm) && o_save_pc == $past(i_next_pc)))
    else $error("system call entry wrong");

  a_illegal_op: assert property (
    (state_r == tcx_pkg::TCX_IDLE && i_sync_req == (24'h1 << `TCX_SRC_ILLEGAL_OPCODE_TRAP)) |=>
      (o_abort && o_class == 3'h2 && o_id == 8'h01 && o_save_pc == $past(i_this_pc)))
    else $error("illegal opcode entry wrong");

  a_fcu_bypass: assert property (
    o_fcu_jump |-> (!o_d15_we && !o_save_we && o_class == 3'h3 && o_id == 8'h04))
    else $error("free list underflow used normal entry");

  a_d15_load: assert property (
    (o_abort && !o_fcu_jump) |-> (o_d15_we && o_d15_data[7:0] == o_id))
    else $error("identification not loaded");

  a_nmi_class: assert property (
    (take_nmi) |=> (o_abort && o_class == 3'h7 && o_id == 8'h00))
    else $error("non-maskable trap entry wrong");

  a_store_pending: assert property (
    (i_store_err && sync_any) |=> store_pend_r)
    else $error("store error lost");

  a_abort_pulse: assert property (o_abort |=> !o_abort)
    else $error("abort longer than one cycle");

  a_store_class: assert property (
    take_store |=> (o_abort && o_class == 3'h4 && o_id == 8'h03))
    else $error("store error entry wrong");

  a_store_held: assert property (
    (store_pend_r && !take_store) |=> store_pend_r)
    else $error("pending store error dropped");

  a_fcu_fetch: assert property (
    (take && sel_fcu) |=> (o_fcu_jump && o_fetch_addr == $past(i_fcu_handler)))
    else $error("free list underflow handler not fetched");

  a_sync_save_pc: assert property (
    (take_sync && sel_cls != `TCX_CLS_SYSTEM_CALL_INSTRUCTION) |=> o_save_pc == $past(i_this_pc))
    else $error("return address is not the trapping instruction");

  a_nmi_pending: assert property (
    nmi_evt |=> nmi_pend_r)
    else $error("non-maskable event lost");

  a_d15_zero_ext: assert property (o_d15_data[31:8] == 24'h00_0000)
    else $error("data register upper bits not zero");

  c_system_call_instruction: cover property (o_abort && o_class == 3'h6);
  c_nmi: cover property (o_abort && o_class == 3'h7);
  c_fcu: cover property (o_fcu_jump);
  c_store: cover property (o_abort && o_class == 3'h4 && o_id == 8'h03);
  c_illegal: cover property (o_abort && o_class == 3'h2 && o_id == 8'h01);
endmodule
`default_nettype wire

// ==== test/tcx_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcx_src_model (
  input wire logic i_ref_clk,
  output logic [23:0] o_sync_req,
  output logic o_store_err,
  output logic o_wdt_nmi,
  output logic o_clk_loss,
  output logic o_nmi_pin
);
  initial begin
    o_sync_req = '0;
    {o_store_err, o_wdt_nmi, o_clk_loss, o_nmi_pin} = 4'h0;
  end
  // Requests are launched just after an edge and held n cycles; the pin stays at its level
  task automatic fire(input logic [23:0] req, input logic [3:0] evt, input int n);
    @(posedge i_ref_clk);
    #1;
    o_sync_req = req;
    {o_store_err, o_wdt_nmi, o_clk_loss, o_nmi_pin} = evt;
    repeat (n) @(posedge i_ref_clk);
    #1;
    o_sync_req = '0;
    {o_store_err, o_wdt_nmi, o_clk_loss} = 3'h0;
  endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] BASE = 32'h8000_0000;
  localparam logic [31:0] FCUH = 32'h0000_4000;
  localparam logic [2:0] CLS [24] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6};
  localparam logic [7:0] IDS [24] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h01, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h01, 8'h02,
    8'h01, 8'h02, 8'h00};
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [31:0] this_pc = 32'h0000_1000;
  logic [7:0] imm = 8'h00;
  logic [23:0] req;
  logic st, wd, cl, np;
  logic o_abort, o_fcu_jump, o_save_we, o_d15_we, o_prio_we;
  logic [31:0] o_fetch_addr, o_save_pc, o_d15_data;
  logic [2:0] o_class;
  logic [7:0] o_id;
  int n_fail = 0;
  int num_checks = 0;

  tcx_src_model src (.i_ref_clk(i_ref_clk), .o_sync_req(req), .o_store_err(st),
    .o_wdt_nmi(wd), .o_clk_loss(cl), .o_nmi_pin(np));

  tcx_trap_classifier #(.ENTRY_SHIFT(5)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_sync_req(req), .i_this_pc(this_pc), .i_next_pc(this_pc + 32'h4),
    .i_system_call_instruction_imm(imm), .i_store_err(st), .i_wdt_nmi(wd), .i_clk_loss(cl),
    .i_nmi_pin(np), .i_vec_base(BASE), .i_fcu_handler(FCUH), .o_abort(o_abort),
    .o_fcu_jump(o_fcu_jump), .o_fetch_addr(o_fetch_addr), .o_class(o_class), .o_id(o_id),
    .o_save_pc(o_save_pc), .o_save_we(o_save_we), .o_d15_we(o_d15_we),
    .o_d15_data(o_d15_data), .o_prio_we(o_prio_we));

  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for one trap entry, judges it, then sees o_abort drop
  task automatic take(input logic [2:0] c, input logic [7:0] id, input logic [31:0] pc,
      input logic fj);
    int k;
    k = 0;
    while (o_abort !== 1'b1 && k < 10) begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    if (k == 10) begin
      n_fail++;
      $display("CHECK FAILED %0t no trap entry", $time);
      finish_test();
    end
    chk(o_class, c);
    chk(o_id, id);
    chk(o_d15_data, {24'h0, id});
    chk(o_d15_we, !fj);
    chk(o_fcu_jump, fj);
    chk(o_save_we, !fj);
    if (!fj) chk(o_save_pc, pc);
    chk(o_fetch_addr, fj ? FCUH : BASE + (32'(c) << 5));
    chk(o_prio_we, 1'b0);
    @(posedge i_ref_clk);
    #1;
    chk(o_abort, 1'b0);
  endtask

  task automatic t_table();
    for (int b = 0; b < 23; b++) begin
      if (b == 15) continue;
      this_pc = 32'h1000 + 32'(b * 4);
      src.fire(24'h1 << b, 4'h0, 1);
      take(CLS[b], IDS[b], this_pc, 1'b0);
    end
  endtask

  task automatic t_system_call_instruction();
    for (int v = 0; v < 2; v++) begin
      imm = v ? 8'hff : 8'h00;
      src.fire(24'h1 << 23, 4'h0, 1);
      take(3'h6, imm, this_pc + 32'h4, 1'b0);
    end
  endtask

  task automatic t_fcu();
    src.fire(24'h1 << 15, 4'h0, 1);
    take(3'h3, 8'h04, this_pc, 1'b1);
  endtask

  // Sync trap, watchdog and store error together: taken one after another
  task automatic t_prio();
    src.fire((24'h1 << 9) | (24'h1 << 23), 4'hc, 1);
    take(3'h2, 8'h01, this_pc, 1'b0);
    take(3'h7, 8'h00, this_pc + 32'h4, 1'b0);
    take(3'h4, 8'h03, this_pc, 1'b0);
  endtask

  // A request held through the flush cycle is taken only once per two cycles
  task automatic t_refuse();
    int cnt;
    cnt = 0;
    fork
      src.fire(24'h1 << 10, 4'h0, 3);
      repeat (7) begin
        @(posedge i_ref_clk);
        #2;
        cnt += (o_abort === 1'b1);
      end
    join
    chk(cnt, 2);
  endtask

  task automatic t_nmi();
    for (int e = 0; e < 3; e++) begin
      src.fire(24'h0, 4'h4 >> e, 1);
      take(3'h7, 8'h00, this_pc + 32'h4, 1'b0);
    end
    src.fire(24'h0, 4'h0, 1);
  endtask

  initial begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    chk(o_abort, 1'b0);
    i_reset = 1'b0;
    t_table();
    t_system_call_instruction();
    t_fcu();
    t_prio();
    t_refuse();
    t_nmi();
    finish_test();
  end
endmodule
`default_nettype wire
